// ---- gsd_pkg.sv ----
// Purpose: Shared constants for the gain strap mode decoder
// Assumes: Gains are carried in tenths of a decibel
// Notes:   Codes and gain figures are fixed by the strap decode table
package gsd_pkg;
    // Gain-select codes
    localparam logic [1:0] GSD_CODE_LOW   = 2'h0;    // Lowest analog gain
    localparam logic [1:0] GSD_CODE_MID   = 2'h1;    // Middle analog gain
    localparam logic [1:0] GSD_CODE_HIGH  = 2'h2;    // Highest analog gain
    localparam logic [1:0] GSD_CODE_SOFT  = 2'h3;    // Software control mode
    // Analog modulator gains, tenths of dBV (19.2, 22.6, 25)
    localparam logic [9:0] GSD_ANA_LOW    = 10'h0c0; // 192
    localparam logic [9:0] GSD_ANA_MID    = 10'h0e2; // 226
    localparam logic [9:0] GSD_ANA_HIGH   = 10'h0fa; // 250
    // Digital boost, tenths of dB (+6 dB)
    localparam logic [9:0] GSD_BOOST      = 10'h03c; // 60
    // Volume reset value, tenths of dB (0 dB, unity)
    localparam logic [9:0] GSD_VOL_UNITY  = 10'h000;
    // Switching frequency multipliers of the sample rate
    localparam logic [4:0] GSD_FSW_LOWPIN = 5'h10;   // 16 x fs
    localparam logic [4:0] GSD_FSW_HIPIN  = 5'h08;   // 8 x fs
    // Reset value of the analog gain output
    localparam logic [9:0] GSD_ANA_RESET  = 10'h0c0;
    // Reset value of the digital path gain, boost plus unity volume (60)
    localparam logic [9:0] GSD_DIG_RESET  = 10'h03c;
    // Reset value of the total gain, digital plus code 00 analog gain (252)
    localparam logic [10:0] GSD_TOT_RESET = 11'h0fc;
    // Control mode
    typedef enum logic {GSD_HW, GSD_SW} gsd_mode_t;
endpackage : gsd_pkg

// ---- gsd_sync2.sv ----
// Purpose: Two-stage synchroniser for a group of strap pins
// Assumes: Single clock, synchronous active-high reset
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module gsd_sync2 #(
    parameter int WIDTH = 4         // Number of bits
) (
    input  wire logic             sys_clk, // System clock
    input  wire logic             reset,   // Synchronous reset
    input  wire logic [WIDTH-1:0] asyncIn, // Pins from outside
    output logic      [WIDTH-1:0] syncOut  // Synchronised pins
);
    logic [WIDTH-1:0] meta_q;   // First stage
    logic [WIDTH-1:0] meta_d;   // First stage next value
    logic [WIDTH-1:0] sync_q;   // Second stage
    logic [WIDTH-1:0] sync_d;   // Second stage next value

    // Next values of both stages
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    // Stage registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;
endmodule // gsd_sync2

// ---- gsd_gain_strap_mode_decoder.sv ----
// Purpose: Decodes gain, bridge and frequency strap pins into mode and gain settings
// Assumes: Strap pins are asynchronous and pass a two-flop synchroniser
// Notes:   Software-side gain arrives on plain ports from the control port logic
`timescale 1ns/1ns

// Overview of operation
// - Total gain is digital plus analog gain
// - Codes 00/01/10 give 19.2/22.6/25 dBV
// - Hardware mode boost fixed at +6 dB
// - Volume resets to unity, held in hardware
// - Code 11 selects software control mode
// - Software mode: bridge and frequency pins become I2C lines
// - Frequency pin low 16x, high 8x fs
// - Bridge pin high gives parallel mono
module gsd_gain_strap_mode_decoder import gsd_pkg::*; (
    input  wire logic       sys_clk,           // 100 MHz clock
    input  wire logic       reset,             // Synchronous reset, active high
    input  wire logic [1:0] gainSelectPins,    // Gain strap pins
    input  wire logic       bridgeModeOrClockPin,   // Bridge strap or I2C clock
    input  wire logic       switchFreqOrDataPin,    // Frequency strap or I2C data
    input  wire logic [9:0] swAnalogGain,      // Analog gain from control port
    input  wire logic [9:0] swDigitalBoost,    // Boost from control port
    input  wire logic [9:0] swVolume,          // Volume from control port
    input  wire logic       swParallelBridge,  // Bridge mode from control port
    input  wire logic [4:0] swSwitchMult,      // Switch multiplier from control port
    output logic            softwareMode,      // High in software control mode
    output logic            i2cClockEnable,    // Bridge pin routed as I2C clock
    output logic            i2cDataEnable,     // Frequency pin routed as I2C data
    output logic            i2cClock,          // I2C clock seen on the pin
    output logic            i2cDataIn,         // I2C data seen on the pin
    output logic [9:0]      analogModulatorGain, // Analog gain, 0.1 dBV
    output logic [9:0]      digitalPathGain,   // Boost plus volume, 0.1 dB
    output logic [9:0]      digitalBoost,      // Boost, 0.1 dB
    output logic [9:0]      volume,            // Volume, 0.1 dB
    output logic [10:0]     totalGain,         // Digital plus analog, 0.1 dB
    output logic            parallelBridgeLoad, // High for mono parallel bridge
    output logic [4:0]      switchFreqMult     // Switching frequency over fs
);
    // Synchronised pins; the straps are static board levels, so the code bits
    // pass the synchroniser side by side and a code change in mid-run may show
    // one mixed code for a single cycle before it settles
    logic [3:0]  pinsSync;   // Synchronised pins: code, bridge, frequency
    logic [1:0]  codeSync;   // Synchronised gain code
    logic        bridgeSync; // Synchronised bridge pin
    logic        freqSync;   // Synchronised frequency pin

    // Mode group
    gsd_mode_t   mode_d;     // Decoded control mode, same cycle
    logic        swFlag_q;   // High while in software control mode
    logic        swFlag_d;   // Next software mode flag

    // Gain group, all in tenths of a decibel
    logic [9:0]  ana_q;      // Analog modulator gain
    logic [9:0]  ana_d;      // Next analog gain
    logic [9:0]  boost_q;    // Digital boost
    logic [9:0]  boost_d;    // Next digital boost
    logic [9:0]  vol_q;      // Volume
    logic [9:0]  vol_d;      // Next volume
    logic [9:0]  dig_q;      // Digital path gain
    logic [9:0]  dig_d;      // Next digital path gain
    logic [10:0] tot_q;      // Total gain
    logic [10:0] tot_d;      // Next total gain

    // Strap function group
    logic        pbl_q;      // Parallel bridge select
    logic        pbl_d;      // Next bridge select
    logic [4:0]  fsw_q;      // Switching frequency multiple
    logic [4:0]  fsw_d;      // Next switching multiple

    // I2C line group
    logic        scl_q;      // I2C clock copy
    logic        scl_d;      // Next clock copy
    logic        sda_q;      // I2C data copy
    logic        sda_d;      // Next data copy

    // Maps a hardware gain code to analog gain
    function automatic logic [9:0] anaForCode(input logic [1:0] code);
        case (code)
            GSD_CODE_LOW:  anaForCode = GSD_ANA_LOW;
            GSD_CODE_MID:  anaForCode = GSD_ANA_MID;
            GSD_CODE_HIGH: anaForCode = GSD_ANA_HIGH;
            default:       anaForCode = GSD_ANA_HIGH;
        endcase
    endfunction

    // Sums two gains with one bit of growth
    function automatic logic [10:0] addGain(input logic [9:0] a, input logic [9:0] b);
        addGain = {1'b0, a} + {1'b0, b};
    endfunction

    // Pin synchroniser
    gsd_sync2 #(.WIDTH(4)) u_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .asyncIn ({gainSelectPins, bridgeModeOrClockPin, switchFreqOrDataPin}),
        .syncOut (pinsSync)
    );

    assign codeSync   = pinsSync[3:2];
    assign bridgeSync = pinsSync[1];
    assign freqSync   = pinsSync[0];

    // Mode decode: code 11 hands gain control to the control port
    always_comb begin
        if (codeSync == GSD_CODE_SOFT) begin
            mode_d = GSD_SW;
        end else begin
            mode_d = GSD_HW;                                    // Straps keep control
        end
        swFlag_d = (mode_d == GSD_SW);
    end

    // Mode register; one flag drives the mode and both routing outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            swFlag_q <= 1'b0;                                   // Hardware mode out of reset
        end else begin
            swFlag_q <= swFlag_d;
        end
    end

    // Gain next values: strap table in hardware mode, control port in software mode
    always_comb begin
        case (mode_d)
            GSD_HW: begin
                ana_d   = anaForCode(codeSync);
                boost_d = GSD_BOOST;
                vol_d   = GSD_VOL_UNITY;
            end
            GSD_SW: begin
                ana_d   = swAnalogGain;
                boost_d = swDigitalBoost;                       // Control port boost
                vol_d   = swVolume;                             // Control port volume
            end
            default: begin
                ana_d   = GSD_ANA_RESET;                        // Unreachable, safe values
                boost_d = GSD_BOOST;
                vol_d   = GSD_VOL_UNITY;
            end
        endcase
        // Digital path is boost plus volume; the carry is dropped on purpose
        dig_d = 10'(addGain(boost_d, vol_d));
        // Total adds the analog gain with one bit of growth kept
        tot_d = addGain(dig_d, ana_d);
    end

    // Gain registers; hardware code 00 values out of reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ana_q   <= GSD_ANA_RESET;                           // Code 00 analog gain
            boost_q <= GSD_BOOST;
            vol_q   <= GSD_VOL_UNITY;
            dig_q   <= GSD_DIG_RESET;                           // Boost plus unity volume
            tot_q   <= GSD_TOT_RESET;                           // Digital plus code 00 gain
        end else begin
            ana_q   <= ana_d;
            boost_q <= boost_d;
            vol_q   <= vol_d;
            dig_q   <= dig_d;
            tot_q   <= tot_d;
        end
    end

    // Strap function next values: bridge mode and switching frequency
    always_comb begin
        case (mode_d)
            GSD_HW: begin
                pbl_d = bridgeSync;
                if (freqSync) begin
                    fsw_d = GSD_FSW_HIPIN;
                end else begin
                    fsw_d = GSD_FSW_LOWPIN;
                end
            end
            GSD_SW: begin
                pbl_d = swParallelBridge;                       // Pin now carries the clock
                fsw_d = swSwitchMult;                           // Pin now carries the data
            end
            default: begin
                pbl_d = 1'b0;                                   // Unreachable, stereo bridge
                fsw_d = GSD_FSW_LOWPIN;
            end
        endcase
    end

    // Strap function registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pbl_q <= 1'b0;                                      // Stereo bridge out of reset
            fsw_q <= GSD_FSW_LOWPIN;                            // 16 x fs out of reset
        end else begin
            pbl_q <= pbl_d;
            fsw_q <= fsw_d;
        end
    end

    // I2C line copies: the shared pins are read as bus lines only in software mode
    always_comb begin
        case (mode_d)
            GSD_SW: begin
                scl_d = bridgeSync;
                sda_d = freqSync;
            end
            default: begin
                scl_d = 1'b0;                                   // Lines read low while strapped
                sda_d = 1'b0;
            end
        endcase
    end

    // I2C line registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            scl_q <= 1'b0;
            sda_q <= 1'b0;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // Outputs straight from registers
    assign softwareMode        = swFlag_q;
    assign i2cClockEnable      = swFlag_q;
    assign i2cDataEnable       = swFlag_q;
    assign i2cClock            = scl_q;
    assign i2cDataIn           = sda_q;
    assign analogModulatorGain = ana_q;
    assign digitalPathGain     = dig_q;
    assign digitalBoost        = boost_q;
    assign volume              = vol_q;
    assign totalGain           = tot_q;
    assign parallelBridgeLoad  = pbl_q;
    assign switchFreqMult      = fsw_q;
endmodule // gsd_gain_strap_mode_decoder

// ---- gsd_strap_model.sv ----
// Purpose: Board strap or I2C host model for the decoder pins
// Assumes: Straps are static levels chosen by the bench
// Notes:   In software mode the shared pins carry I2C clock and data
`timescale 1ns/1ns
module gsd_strap_model (
    input  wire logic [1:0] code,      // Requested gain code
    input  wire logic       bridge,    // Bridge strap or clock level
    input  wire logic       freq,      // Frequency strap or data level
    output logic      [1:0] gainPins,  // Gain strap pins
    output logic            bridgePin, // Bridge or clock pin
    output logic            freqPin    // Frequency or data pin
);
    // Resistors hold the pins at the requested levels
    assign gainPins  = code;
    assign bridgePin = bridge;
    assign freqPin   = freq;
endmodule // gsd_strap_model

// ---- gsd_props.sv ----
// Purpose: Port assertions for the gain strap decoder
// Assumes: Pins reach the outputs three edges after a change
// Notes:   Bound onto the decoder top module
`timescale 1ns/1ns
module gsd_props import gsd_pkg::*; (
    input wire logic        sys_clk,              // System clock
    input wire logic        reset,                // Synchronous reset, active high
    input wire logic [1:0]  gainSelectPins,       // Gain straps
    input wire logic        bridgeModeOrClockPin, // Bridge strap or I2C clock
    input wire logic        switchFreqOrDataPin,  // Frequency strap or I2C data
    input wire logic [9:0]  swAnalogGain,         // Control port analog gain
    input wire logic [9:0]  analogModulatorGain,  // Analog gain
    input wire logic [9:0]  digitalPathGain,      // Boost plus volume
    input wire logic [9:0]  digitalBoost,         // Boost
    input wire logic [9:0]  volume,               // Volume
    input wire logic [10:0] totalGain,            // Sum
    input wire logic        softwareMode,         // Mode flag
    input wire logic        i2cClockEnable,       // Clock routing
    input wire logic        i2cDataEnable,        // Data routing
    input wire logic        i2cClock,             // Clock copy
    input wire logic        i2cDataIn,            // Data copy
    input wire logic        parallelBridgeLoad,   // Bridge mode
    input wire logic [4:0]  switchFreqMult        // Frequency multiple
);
    logic [1:0] since_q; // Edges since reset, stops at 3
    logic [1:0] since_d; // Next edge count
    always_comb since_d = reset ? 2'h0 : since_q + {1'b0, since_q != 2'h3};
    always_ff @(posedge sys_clk) since_q <= since_d;
    wire settled = since_q == 2'h3; // Synchroniser now holds real pin samples
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Expected analog gain of a hardware code
    function automatic logic [9:0] anaOf(input logic [1:0] c);
        return c == GSD_CODE_LOW ? GSD_ANA_LOW : c == GSD_CODE_MID ? GSD_ANA_MID : GSD_ANA_HIGH;
    endfunction
    a_total_sum: assert property (
        totalGain == 11'(digitalPathGain) + 11'(analogModulatorGain))
        else $error("total gain is not digital plus analog");
    a_gain_decode: assert property (
        settled && !softwareMode |-> analogModulatorGain == anaOf($past(gainSelectPins, 3)))
        else $error("analog gain does not match code");
    a_boost_fixed: assert property (!softwareMode |-> digitalBoost == GSD_BOOST)
        else $error("boost not fixed in hardware mode");
    a_volume_unity: assert property (
        !softwareMode |-> volume == GSD_VOL_UNITY && digitalPathGain == GSD_BOOST)
        else $error("volume not unity in hardware mode");
    a_soft_entry: assert property (
        settled |-> softwareMode == ($past(gainSelectPins, 3) == GSD_CODE_SOFT))
        else $error("mode does not follow code");
    a_soft_gain: assert property (
        softwareMode && $past(softwareMode) |-> analogModulatorGain == $past(swAnalogGain))
        else $error("software gain not taken");
    a_i2c_route: assert property (
        settled |-> i2cClockEnable == softwareMode && i2cDataEnable == softwareMode &&
            (softwareMode ? i2cClock == $past(bridgeModeOrClockPin, 3) &&
                            i2cDataIn == $past(switchFreqOrDataPin, 3)
                          : !(i2cClock || i2cDataIn)))
        else $error("pins not routed as I2C");
    a_freq_select: assert property (
        settled && !softwareMode |->
            switchFreqMult == ($past(switchFreqOrDataPin, 3) ? GSD_FSW_HIPIN : GSD_FSW_LOWPIN))
        else $error("wrong switching multiple");
    a_bridge_select: assert property (
        settled && !softwareMode |-> parallelBridgeLoad == $past(bridgeModeOrClockPin, 3))
        else $error("wrong bridge mode");
    c_soft_mode: cover property (softwareMode && i2cClockEnable);
    c_high_gain: cover property (analogModulatorGain == GSD_ANA_HIGH);
    c_slow_freq: cover property (!softwareMode && switchFreqMult == GSD_FSW_HIPIN);
endmodule // gsd_props
bind gsd_gain_strap_mode_decoder gsd_props gsd_props_inst (.sys_clk, .reset, .gainSelectPins,
    .bridgeModeOrClockPin, .switchFreqOrDataPin, .swAnalogGain, .analogModulatorGain,
    .digitalPathGain, .digitalBoost, .volume, .totalGain, .softwareMode, .i2cClockEnable,
    .i2cDataEnable, .i2cClock, .i2cDataIn, .parallelBridgeLoad, .switchFreqMult);

// ---- gain_strap_mode_decoder_tb_top.sv ----
// Purpose: Self-checking bench for the gain strap decoder
// Assumes: Pins settle on the outputs three edges after a change
// Notes:   Control port values stay non-zero to show they are ignored in hardware mode
`timescale 1ns/1ns
module gain_strap_mode_decoder_tb_top import gsd_pkg::*;;
    logic sys_clk = 1'b0, reset = 1'b1, bridge = 1'b0, freq = 1'b0, swParallelBridge = 1'b1;
    logic [1:0] code = 2'h0, gainSelectPins; // Strap code and pins
    logic bridgeModeOrClockPin, switchFreqOrDataPin, parallelBridgeLoad; // Pins, bridge out
    logic [9:0] swAnalogGain = 10'h123, swDigitalBoost = 10'h01e, swVolume = 10'h014;
    logic [4:0] swSwitchMult = 5'h04, switchFreqMult; // Multiples in and out
    logic softwareMode, i2cClockEnable, i2cDataEnable, i2cClock, i2cDataIn; // Mode outputs
    logic [9:0] analogModulatorGain, digitalPathGain, digitalBoost, volume; // Gain outputs
    logic [10:0] totalGain; // Sum output
    int err_count = 0, total_checks = 0, cycles = 0; // Counters
    gsd_strap_model gsd_strap_model_inst (.code, .bridge, .freq, .gainPins(gainSelectPins),
        .bridgePin(bridgeModeOrClockPin), .freqPin(switchFreqOrDataPin));
    gsd_gain_strap_mode_decoder gsd_gain_strap_mode_decoder_inst (.sys_clk, .reset,
        .gainSelectPins, .bridgeModeOrClockPin, .switchFreqOrDataPin, .swAnalogGain,
        .swDigitalBoost, .swVolume, .swParallelBridge, .swSwitchMult, .softwareMode,
        .i2cClockEnable, .i2cDataEnable, .i2cClock, .i2cDataIn, .analogModulatorGain,
        .digitalPathGain, .digitalBoost, .volume, .totalGain, .parallelBridgeLoad,
        .switchFreqMult);
    initial forever #5 sys_clk = ~sys_clk;
    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 500) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up; // Verdict and end of run
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] exp, got); // Compare and count
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic strap(input logic [1:0] c, input logic b, f); // Set pins, wait out sync
        code = c;
        bridge = b;
        freq = f;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic hw(input logic [1:0] c, input logic b, f, input logic [9:0] ana); // Hw case
        strap(c, b, f);
        chk("analog", 11'(ana), 11'(analogModulatorGain));
        chk("boost", 11'(GSD_BOOST), 11'(digitalBoost));
        chk("volume", 11'(GSD_VOL_UNITY), 11'(volume));
        chk("digital", 11'(GSD_BOOST), 11'(digitalPathGain));
        chk("hw lines", 11'h0, 11'({i2cClock, i2cDataIn}));
        chk("total", 11'(ana) + 11'(GSD_BOOST), totalGain);
        chk("bridge", 11'(b), 11'(parallelBridgeLoad));
        chk("mult", 11'(f ? GSD_FSW_HIPIN : GSD_FSW_LOWPIN), 11'(switchFreqMult));
        chk("mode", 11'h0, 11'({softwareMode, i2cClockEnable, i2cDataEnable}));
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 reset = 1'b0;
        chk("reset total", 11'(GSD_ANA_RESET) + 11'(GSD_BOOST), totalGain);
        hw(GSD_CODE_LOW, 1'b0, 1'b0, GSD_ANA_LOW);
        hw(GSD_CODE_MID, 1'b1, 1'b0, GSD_ANA_MID);
        hw(GSD_CODE_HIGH, 1'b0, 1'b1, GSD_ANA_HIGH);
        strap(GSD_CODE_SOFT, 1'b1, 1'b0);
        chk("mode", 11'h7, 11'({softwareMode, i2cClockEnable, i2cDataEnable}));
        chk("analog", 11'h123, 11'(analogModulatorGain));
        chk("total", 11'h155, totalGain);
        chk("lines", 11'h2, 11'({i2cClock, i2cDataIn}));
        chk("sw boost", 11'h01e, 11'(digitalBoost));
        chk("sw volume", 11'h014, 11'(volume));
        chk("sw digital", 11'h032, 11'(digitalPathGain));
        chk("sw bridge", 11'h001, 11'(parallelBridgeLoad));
        chk("sw mult", 11'h004, 11'(switchFreqMult));
        strap(GSD_CODE_SOFT, 1'b0, 1'b1);
        chk("lines", 11'h1, 11'({i2cClock, i2cDataIn}));
        hw(GSD_CODE_MID, 1'b1, 1'b1, GSD_ANA_MID);
        reset = 1'b1;
        @(posedge sys_clk);
        #1 reset = 1'b0;
        chk("reset mult", 11'(GSD_FSW_LOWPIN), 11'(switchFreqMult));
        chk("reset analog", 11'(GSD_ANA_RESET), 11'(analogModulatorGain));
        chk("reset mode", 11'h0, 11'({softwareMode, i2cClockEnable, i2cDataEnable}));
        chk("reset digital", 11'(GSD_BOOST) + 11'(GSD_VOL_UNITY), 11'(digitalPathGain));
        wrap_up();
    end
endmodule // gain_strap_mode_decoder_tb_top
